/* File: hdl/uevr_regs.sv */
`timescale 1ns/1ps
module uevr_regs #(
   parameter int NUM_EP = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // AXI4-Lite write channels
   input wire logic [uevr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [uevr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Handshake events from the USB engine, one-cycle pulses
   input wire logic [NUM_EP-1:0] nak_in_ep,
   input wire logic [NUM_EP-1:0] nak_out_ep,
   input wire logic nyet_out_ep0,
   input wire logic nyet_out_ep2,
   // Protocol error events, one-cycle pulses
   input wire logic err_token,
   input wire logic err_stall,
   input wire logic err_toggle,
   input wire logic err_rxfault,
   input wire logic err_crc,
   // Buffer B transmit setup
   output logic full_block_flag,
   output logic count_bit_eight,
   output logic [7:0] bufb_count_low,
   output logic [15:0] bufb_sram_base,
   // Status to the controller
   output logic handshake_event_irq,
   output logic usb_error_summary
);
   import uevr_pkg::*;

   uevr_reg_if rif ();

   // Bus slave: takes the AXI channels, presents single-cycle strobes
   uevr_axil_slave u_axil (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .s_axi_awaddr (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata (s_axi_wdata),
      .s_axi_wstrb (s_axi_wstrb),
      .s_axi_wvalid (s_axi_wvalid),
      .s_axi_wready (s_axi_wready),
      .s_axi_bresp (s_axi_bresp),
      .s_axi_bvalid (s_axi_bvalid),
      .s_axi_bready (s_axi_bready),
      .s_axi_araddr (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata (s_axi_rdata),
      .s_axi_rresp (s_axi_rresp),
      .s_axi_rvalid (s_axi_rvalid),
      .s_axi_rready (s_axi_rready),
      .rif (rif.bus_side)
   );

   logic [7:0] cnt_hi, next_cnt_hi;
   logic [7:0] cnt_lo, next_cnt_lo;
   logic [7:0] hs_flags, next_hs_flags;
   logic [7:0] hs_mask, next_hs_mask;
   logic [7:0] err_flags, next_err_flags;
   logic [7:0] hs_set, err_set;
   logic [7:0] wr_idx, rd_idx;
   logic wr_ok;
   logic [7:0] usb_stat;

   // Word index is address bits 9..2; upper bits and byte offset must be zero
   function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      idx_mapped = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) &&
                   (i == IDX_CNT_HI || i == IDX_CNT_LO || i == IDX_HS_FLAGS ||
                    i == IDX_HS_MASK || i == IDX_ERR_FLAGS || i == IDX_USB_STAT);
   endfunction : idx_mapped

   // Decode; unmapped words answer SLVERR and touch nothing
   assign wr_idx = rif.wr_addr[9:2];
   assign rd_idx = rif.rd_addr[9:2];
   assign rif.wr_hit = idx_mapped(rif.wr_addr);
   assign rif.rd_hit = idx_mapped(rif.rd_addr);
   // A write without byte lane 0 is acknowledged but changes nothing
   assign wr_ok = rif.wr_go && rif.wr_hit && rif.wr_lane;

   // Per-endpoint NAK events land on bit pairs: IN at 2n+1, OUT at 2n
   for (genvar ep = 0; ep < NUM_EP; ep++) begin : g_nak
      assign hs_set[2*ep+1] = nak_in_ep[ep];
      assign hs_set[2*ep] = nak_out_ep[ep];
   end
   assign hs_set[HS_NYET_EP2] = nyet_out_ep2;
   assign hs_set[HS_NYET_EP0] = nyet_out_ep0;

   // Error events; reserved positions never set
   always_comb begin
      err_set = 8'h00;
      err_set[ERR_TOKEN] = err_token;
      err_set[ERR_STALL] = err_stall;
      err_set[ERR_TOGGLE] = err_toggle;
      err_set[ERR_RXFAULT] = err_rxfault;
      err_set[ERR_CRC] = err_crc;
   end

   // Next register values; a set in the clearing cycle survives the clear
   always_comb begin
      next_cnt_hi = cnt_hi;
      next_cnt_lo = cnt_lo;
      next_hs_mask = hs_mask;
      next_hs_flags = hs_flags;
      next_err_flags = err_flags;
      if (wr_ok && wr_idx == IDX_CNT_HI) begin
         next_cnt_hi = rif.wr_data & CNT_HI_BITS;
      end
      if (wr_ok && wr_idx == IDX_CNT_LO) begin
         next_cnt_lo = rif.wr_data;
      end
      if (wr_ok && wr_idx == IDX_HS_MASK) begin
         next_hs_mask = rif.wr_data;
      end
      if (wr_ok && wr_idx == IDX_HS_FLAGS) begin
         next_hs_flags = hs_flags & ~rif.wr_data;
      end
      if (wr_ok && wr_idx == IDX_ERR_FLAGS) begin
         next_err_flags = err_flags & ~rif.wr_data;
      end
      next_hs_flags = next_hs_flags | hs_set;
      next_err_flags = (next_err_flags | err_set) & ERR_BITS;
   end

   // Register storage
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_hi <= RST_CNT_HI;
         cnt_lo <= RST_CNT_LO;
         hs_flags <= RST_HS_FLAGS;
         hs_mask <= RST_HS_MASK;
         err_flags <= RST_ERR_FLAGS;
      end else begin
         cnt_hi <= next_cnt_hi;
         cnt_lo <= next_cnt_lo;
         hs_flags <= next_hs_flags;
         hs_mask <= next_hs_mask;
         err_flags <= next_err_flags;
      end
   end

   // Status word holds the error summary only
   always_comb begin
      usb_stat = 8'h00;
      usb_stat[STAT_ERR_SUM] = |err_flags;
   end

   // Read mux; reads have no side effects so the flags are safe to poll
   always_comb begin
      rif.rd_data = 8'h00;
      if (rif.rd_hit) begin
         unique case (rd_idx)
            IDX_CNT_HI: rif.rd_data = cnt_hi & CNT_HI_BITS;
            IDX_CNT_LO: rif.rd_data = cnt_lo;
            IDX_HS_FLAGS: rif.rd_data = hs_flags;
            IDX_HS_MASK: rif.rd_data = hs_mask;
            IDX_ERR_FLAGS: rif.rd_data = err_flags & ERR_BITS;
            IDX_USB_STAT: rif.rd_data = usb_stat;
            default: rif.rd_data = 8'h00;
         endcase
      end
   end

   // Count outputs straight from the register flops, SRAM base from a package constant
   assign full_block_flag = cnt_hi[CNT_HI_FULL];
   assign count_bit_eight = cnt_hi[CNT_HI_BIT8];
   assign bufb_count_low = cnt_lo;
   assign bufb_sram_base = BUFB_SRAM_BASE;
   // Level interrupt; firmware must clear the flag or mask it to drop it
   assign handshake_event_irq = |(hs_flags & ~hs_mask);
   assign usb_error_summary = usb_stat[STAT_ERR_SUM];

   // Checks on the register behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   logic wr_hs, wr_err, wr_hi;
   assign wr_hs = wr_ok && wr_idx == IDX_HS_FLAGS;
   assign wr_err = wr_ok && wr_idx == IDX_ERR_FLAGS;
   assign wr_hi = wr_ok && wr_idx == IDX_CNT_HI;

   a_full_block_wr:
   assert property (wr_hi |=> full_block_flag == $past(rif.wr_data[1]))
      else $error("full block flag not written");
   a_bit_eight_wr:
   assert property (wr_hi |=> count_bit_eight == $past(rif.wr_data[0]) [*2])
      else $error("count bit eight not held");
   a_hi_reserved:
   assert property (rif.rd_go && rd_idx == IDX_CNT_HI |-> rif.rd_data[7:2] == 6'h00)
      else $error("reserved count bits read nonzero");
   a_low_count_wr:
   assert property (wr_ok && wr_idx == IDX_CNT_LO |=> bufb_count_low == $past(rif.wr_data))
      else $error("low count not written");
   a_nyet_sets:
   assert property (nyet_out_ep2 |=> hs_flags[7] ##1 (hs_flags[7] || $past(wr_hs)))
      else $error("ep2 nyet flag not set");
   a_nak_in_sets:
   assert property (nak_in_ep[1] |=> hs_flags[3])
      else $error("ep1 in nak flag not set");
   a_nak_out_sets:
   assert property (nak_out_ep[0] |=> hs_flags[0])
      else $error("ep0 out nak flag not set");
   a_irq_unmasked:
   assert property (hs_flags[2] && !hs_mask[2] |-> handshake_event_irq)
      else $error("unmasked flag gave no interrupt");
   a_irq_masked:
   assert property (hs_mask == 8'hff |-> !handshake_event_irq)
      else $error("interrupt while fully masked");
   a_hs_clear:
   assert property (wr_hs && rif.wr_data[3] && !hs_set[3] |=> !hs_flags[3])
      else $error("handshake flag not cleared");
   a_hs_keep:
   assert property (wr_hs && hs_flags[5] && !rif.wr_data[5] |=> hs_flags[5])
      else $error("handshake flag lost on zero write");
   a_mask_reset:
   assert property (disable iff (1'b0) sys_rst |=> hs_mask == 8'hff && hs_flags == 8'h00)
      else $error("mask reset value wrong");
   a_token_err:
   assert property (err_token |=> err_flags[6])
      else $error("token error not flagged");
   a_stall_err:
   assert property (err_stall |=> err_flags[4])
      else $error("stall error not flagged");
   a_toggle_err:
   assert property (err_toggle |=> err_flags[3])
      else $error("toggle error not flagged");
   a_rxfault_err:
   assert property (err_rxfault |=> err_flags[2])
      else $error("receive fault not flagged");
   a_crc_err:
   assert property (err_crc |=> err_flags[0])
      else $error("crc error not flagged");
   a_err_reserved:
   assert property (err_flags[7] == 1'b0 && err_flags[5] == 1'b0 && err_flags[1] == 1'b0)
      else $error("reserved error bit set");
   a_err_clear:
   assert property (wr_err && rif.wr_data[6] && !err_token |=> !err_flags[6])
      else $error("error flag not cleared");
   a_err_summary:
   assert property ($rose(|err_flags) |-> usb_error_summary throughout (|err_flags))
      else $error("error summary not following flags");
   a_set_wins:
   assert property (wr_hs && rif.wr_data[7] && nyet_out_ep2 |=> hs_flags[7])
      else $error("clear beat a coincident set");
   a_sticky:
   assert property (hs_flags[1] && !wr_hs |=> hs_flags[1])
      else $error("handshake flag dropped by itself");

   // Main scenarios
   c_irq_raised: cover property ($rose(handshake_event_irq));
   c_irq_cleared: cover property (handshake_event_irq ##1 wr_hs ##1 !handshake_event_irq);
   c_err_summary: cover property ($rose(usb_error_summary));
   c_set_on_clear: cover property (wr_hs && nyet_out_ep2 && rif.wr_data[7]);
   c_slverr: cover property (rif.wr_go && !rif.wr_hit);
endmodule : uevr_regs

/* File: include/uevr_pkg.sv */
package uevr_pkg;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_CNT_HI = 8'hd5;
   localparam logic [7:0] IDX_CNT_LO = 8'hd6;
   localparam logic [7:0] IDX_HS_FLAGS = 8'hd7;
   localparam logic [7:0] IDX_HS_MASK = 8'hd9;
   localparam logic [7:0] IDX_ERR_FLAGS = 8'hda;
   localparam logic [7:0] IDX_USB_STAT = 8'he0;
   // Reset values
   localparam logic [7:0] RST_CNT_HI = 8'h00;
   localparam logic [7:0] RST_CNT_LO = 8'h00;
   localparam logic [7:0] RST_HS_FLAGS = 8'h00;
   localparam logic [7:0] RST_HS_MASK = 8'hff;
   localparam logic [7:0] RST_ERR_FLAGS = 8'h00;
   // Implemented bits, all others read as zero
   localparam logic [7:0] CNT_HI_BITS = 8'h03;
   localparam logic [7:0] ERR_BITS = 8'h5d;
   // Field positions
   localparam int CNT_HI_FULL = 1;
   localparam int CNT_HI_BIT8 = 0;
   localparam int HS_NYET_EP2 = 7;
   localparam int HS_NYET_EP0 = 6;
   localparam int ERR_TOKEN = 6;
   localparam int ERR_STALL = 4;
   localparam int ERR_TOGGLE = 3;
   localparam int ERR_RXFAULT = 2;
   localparam int ERR_CRC = 0;
   localparam int STAT_ERR_SUM = 0;
   // Shared SRAM start of the buffer B packet
   localparam logic [15:0] BUFB_SRAM_BASE = 16'h0300;
   // Bus shape
   localparam int ADDR_W = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uevr_pkg

/* File: include/uevr_reg_if.sv */
`timescale 1ns/1ps
interface uevr_reg_if;
   logic wr_go;
   logic [uevr_pkg::ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane;
   logic wr_hit;
   logic rd_go;
   logic [uevr_pkg::ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_hit;
   // Bus adapter side
   modport bus_side (output wr_go, wr_addr, wr_data, wr_lane, rd_go, rd_addr,
                     input wr_hit, rd_data, rd_hit);
   // Register bank side
   modport bank_side (input wr_go, wr_addr, wr_data, wr_lane, rd_go, rd_addr,
                      output wr_hit, rd_data, rd_hit);
endinterface : uevr_reg_if

/* File: hdl/uevr_axil_slave.sv */
`timescale 1ns/1ps
module uevr_axil_slave (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Write channels
   input wire logic [uevr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic [uevr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Register bank
   uevr_reg_if.bus_side rif
);
   import uevr_pkg::*;
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [7:0] w_data, next_w_data;
   logic w_lane, next_w_lane;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;

   // Address and data are parked until both are in, in either order
   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready = !w_held && !bvalid;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign rif.wr_go = aw_held && w_held && !bvalid;
   assign rif.wr_addr = aw_addr;
   assign rif.wr_data = w_data;
   assign rif.wr_lane = w_lane;
   assign rif.rd_go = s_axi_arvalid && !rvalid;
   assign rif.rd_addr = s_axi_araddr;

   // Channel state; only byte lane 0 carries register data
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_lane = w_lane;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata[7:0];
         next_w_lane = s_axi_wstrb[0];
      end
      if (rif.wr_go) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (rif.rd_go) begin
         next_rvalid = 1'b1;
         next_rdata = {24'h000000, rif.rd_data};
         next_rresp = rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // Registers only
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= 8'h00;
         w_lane <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_lane <= next_w_lane;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end
endmodule : uevr_axil_slave

/* File: bench/uevr_usb_engine_model.sv */
`timescale 1ns/1ps
// Far-side USB engine: each requested event becomes a one-cycle pulse
module uevr_usb_engine_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Event requests from the bench, bit order as the pulses below
   input wire logic [12:0] fire,
   // Handshake event pulses
   output logic [2:0] nak_in_ep,
   output logic [2:0] nak_out_ep,
   output logic nyet_out_ep0,
   output logic nyet_out_ep2,
   // Protocol error pulses
   output logic err_token,
   output logic err_stall,
   output logic err_toggle,
   output logic err_rxfault,
   output logic err_crc
);
   logic [12:0] pulse;
   // Registered so a pulse never carries a glitch from the bench drive
   always_ff @(posedge clk_sys) begin
      pulse <= sys_rst ? 13'h0000 : fire;
   end
   // Fan out to the engine outputs
   assign nak_in_ep = pulse[2:0];
   assign nak_out_ep = pulse[5:3];
   assign nyet_out_ep0 = pulse[6];
   assign nyet_out_ep2 = pulse[7];
   assign {err_crc, err_rxfault, err_toggle, err_stall, err_token} = pulse[12:8];
endmodule : uevr_usb_engine_model

/* File: bench/usb_endpoint_event_regs_bench.sv */
`timescale 1ns/1ps
module usb_endpoint_event_regs_bench;
   import uevr_pkg::*;
   logic clk_sys, sys_rst;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [2:0] nak_in_ep, nak_out_ep;
   logic nyet_out_ep0, nyet_out_ep2, err_token, err_stall, err_toggle, err_rxfault, err_crc;
   logic full_block_flag, count_bit_eight, handshake_event_irq, usb_error_summary;
   logic [7:0] bufb_count_low;
   logic [15:0] bufb_sram_base;
   logic [31:0] rdv;
   logic [12:0] fire;
   int error_cnt, n_checks, d;
   // Reference model state and event to flag bit table
   int exp_hs, exp_err, exp_mask, exp_hi, exp_lo;
   int bit_of[13] = '{1, 3, 5, 0, 2, 4, 6, 7, 6, 4, 3, 2, 0};

   uevr_regs uevr_regs_inst (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .nak_in_ep, .nak_out_ep, .nyet_out_ep0, .nyet_out_ep2,
      .err_token, .err_stall, .err_toggle, .err_rxfault, .err_crc, .full_block_flag,
      .count_bit_eight, .bufb_count_low, .bufb_sram_base, .handshake_event_irq,
      .usb_error_summary);
   uevr_usb_engine_model uevr_usb_engine_model_inst (.clk_sys, .sys_rst, .fire, .nak_in_ep,
      .nak_out_ep, .nyet_out_ep0, .nyet_out_ep2, .err_token, .err_stall, .err_toggle,
      .err_rxfault, .err_crc);

   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : addr_of

   // Entered just after an edge; both write channels offered together, bready held
   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] v,
                            input logic [3:0] strb, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, v};
      s_axi_wstrb <= strb;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 40) begin
         error_cnt++;
         report_and_stop();
      end
      // Let an edge pass so a following call never re-drives bready in this step
      @(posedge clk_sys);
   endtask : axi_write

   task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] v,
                           output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 40) begin
         error_cnt++;
         report_and_stop();
      end
      // Let an edge pass so a following call never re-drives rready in this step
      @(posedge clk_sys);
   endtask : axi_read

   task automatic wr(input logic [7:0] idx, input int v);
      logic [1:0] r;
      axi_write(addr_of(idx), v[7:0], 4'h1, r);
      check("bresp", r, 2'h0);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input int exp, input string what);
      logic [31:0] v;
      logic [1:0] r;
      axi_read(addr_of(idx), v, r);
      check(what, v, exp & 255);
      check("rresp", r, 2'h0);
   endtask : rd_chk

   // Pulse events through the engine model and fold them into the reference
   task automatic fire_ev(input logic [12:0] ev);
      fire <= ev;
      @(posedge clk_sys);
      fire <= 13'h0000;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < 13; i++) begin
         if (ev[i] && i < 8) exp_hs |= 1 << bit_of[i];
         if (ev[i] && i >= 8) exp_err |= 1 << bit_of[i];
      end
   endtask : fire_ev

   // Every register and output against the reference
   task automatic check_all();
      rd_chk(IDX_CNT_HI, exp_hi & 3, "count high");
      rd_chk(IDX_CNT_LO, exp_lo, "count low");
      rd_chk(IDX_HS_FLAGS, exp_hs, "hs flags");
      rd_chk(IDX_HS_MASK, exp_mask, "hs mask");
      rd_chk(IDX_ERR_FLAGS, exp_err, "err flags");
      rd_chk(IDX_ERR_FLAGS, exp_err, "err flags");
      rd_chk(IDX_USB_STAT, exp_err != 0, "usb status");
      check("irq", handshake_event_irq, (exp_hs & ~exp_mask & 255) != 0);
      check("summary", usb_error_summary, exp_err != 0);
      check("full block", full_block_flag, exp_hi[1]);
      check("count bit eight", count_bit_eight, exp_hi[0]);
      check("count low out", bufb_count_low, exp_lo);
      check("sram base", bufb_sram_base, 16'h0300);
   endtask : check_all

   // Reset reference values
   task automatic model_reset();
      exp_hs = 0;
      exp_err = 0;
      exp_mask = 255;
      exp_hi = 0;
      exp_lo = 0;
   endtask : model_reset

   // Hang guard, far beyond the expected run of under two thousand cycles
   initial begin
      #500000;
      error_cnt++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, fire} = '0;
      void'($urandom(32'h5b5f9b59));
      model_reset();
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      check_all();
      // Count registers with random values, reserved bits written with random values too
      repeat (4) begin
         d = $urandom;
         wr(IDX_CNT_HI, d);
         exp_hi = d & 3;
         d = $urandom;
         wr(IDX_CNT_LO, d);
         exp_lo = d & 255;
         check_all();
      end
      // Lane zero not enabled leaves the register alone
      axi_write(addr_of(IDX_CNT_LO), ~exp_lo[7:0], 4'h0, resp);
      check("bresp", resp, 2'h0);
      // Each event alone under a random mask; a zero write keeps it, a one clears it
      for (int i = 0; i < 13; i++) begin
         d = $urandom;
         wr(IDX_HS_MASK, d);
         exp_mask = d & 255;
         fire_ev(13'h0001 << i);
         check_all();
         wr(i < 8 ? IDX_HS_FLAGS : IDX_ERR_FLAGS, 0);
         check_all();
         wr(i < 8 ? IDX_HS_FLAGS : IDX_ERR_FLAGS, 1 << bit_of[i]);
         if (i < 8) exp_hs = 0;
         else exp_err = 0;
         check_all();
      end
      // Random bursts and partial clears
      repeat (6) begin
         fire_ev(13'($urandom));
         check_all();
         d = $urandom;
         wr(IDX_HS_FLAGS, d);
         exp_hs &= ~d;
         wr(IDX_ERR_FLAGS, d >> 8);
         exp_err &= ~(d >> 8);
         check_all();
      end
      // Set in the same cycle as a clear wins
      fire_ev(13'h0080);
      fork
         axi_write(addr_of(IDX_HS_FLAGS), 8'h80, 4'h1, resp);
         begin
            fire <= 13'h0080;
            @(posedge clk_sys);
            fire <= 13'h0000;
         end
      join
      check_all();
      // Unmapped place refused, status register ignores writes
      axi_write(12'h004, 8'hff, 4'h1, resp);
      check("bresp unmapped", resp, 2'h2);
      axi_read(12'h004, rdv, resp);
      check("rresp unmapped", resp, 2'h2);
      wr(IDX_USB_STAT, 255);
      check_all();
      // Second reset in mid-run
      fire_ev(13'h1fff);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      model_reset();
      check_all();
      report_and_stop();
   end
endmodule : usb_endpoint_event_regs_bench
